/* src/apb_reg_decode.sv */
// apb phase and address decode for the counter flag registers
module apb_reg_decode
  import rx_flags_pkg::*;
(
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  output logic             setupPhase,
  output logic             wrDone,
  output logic             rdDone,
  output logic             selCtrl,
  output logic             selFlags,
  output logic             selMask,
  output logic             selCnt,
  output logic      [4:0]  cntIdx,
  output logic             mapped
);

  logic [11:0] cntOfs;

  always_comb
  begin
    cntOfs     = paddr - CNT_BASE_OFFSET;
    setupPhase = psel && !penable;
    // zero wait: pready is always high, so every access phase completes
    wrDone     = psel && penable && pwrite;
    rdDone     = psel && penable && !pwrite;
    selCtrl    = paddr == CTRL_OFFSET;
    selFlags   = paddr == FLAGS_OFFSET;
    selMask    = paddr == MASK_OFFSET;
    selCnt     = paddr >= CNT_BASE_OFFSET && cntOfs[1:0] == 2'h0
                 && cntOfs[11:2] < 10'(NUM_CNT);
    cntIdx     = cntOfs[6:2];
    mapped     = selCtrl || selFlags || selMask || selCnt;
  end
endmodule

/* src/cnt_ctrl_if.sv */
// shared counter control lines from the register block to every counter
interface cnt_ctrl_if;
  logic resetAll;
  logic preset;
  logic presetFull;
  logic freeze;
  logic stopRoll;
  logic clrOnRead;

  modport ctl (output resetAll, preset, presetFull, freeze, stopRoll, clrOnRead);
  modport cnt (input resetAll, preset, presetFull, freeze, stopRoll, clrOnRead);
endinterface

/* src/rx_flags_pkg.sv */
// constants, register map and state types for the receive counter event flag block
//
// Contract
// - each flag goes to 1 when its receive counter reaches half scale and again at full scale.
// - half scale is the most significant bit alone, 0x8000_0000 at 32 bits and 0x8000 at 16.
// - full scale is all ones in the counter width, 0xFFFF at 16 bits and all ones at 32.
// - with rollover prevention the flag still sets at full scale but the counter stays at ones.
// - a flag is cleared only by a read of its own counter; reading other counters leaves it.
// - the clearing read must cover byte lane bits[7:0] of that counter, and only it clears.
// - the flag register is 32 bits wide, flags sit in bits 0..23 and reset to 0.
// - flags are set only by counter events; reading the flag register clears nothing.
// - bit 0 is all frames, bit 1 all octets, bit 2 good octets.
// - bits 3..8 are broadcast, multicast, crc, alignment, runt and jabber counters.
// - bits 9..16 are undersize, oversize and the six frame size buckets up to maximum.
// - bits 17..23 are unicast, length, out of range type, pause, overrun, tagged, watchdog.
// - control bit 1 set makes a counter saturate at its maximum instead of wrapping.
// - control bit 2 set makes a read of a counter's low byte lane also zero that counter.
// - preset loads counters below a threshold; half: octets 0x7FFF_F800, frames 0x7FFF_FFF0.
package rx_flags_pkg;

  // ==========================================================================
  // register map
  localparam logic [11:0] CTRL_OFFSET     = 12'h100;
  localparam logic [11:0] FLAGS_OFFSET    = 12'h104;
  localparam logic [11:0] MASK_OFFSET     = 12'h10c;
  localparam logic [11:0] CNT_BASE_OFFSET = 12'h180;
  localparam int          NUM_CNT         = 24;
  localparam int          CNT_W           = 32;

  // control bit positions
  localparam int CTRL_CNT_RESET_BIT   = 0;
  localparam int CTRL_STOP_ROLL_BIT   = 1;
  localparam int CTRL_CLR_ON_READ_BIT = 2;
  localparam int CTRL_FREEZE_BIT      = 3;
  localparam int CTRL_PRESET_BIT      = 4;
  localparam int CTRL_PRESET_FULL_BIT = 5;
  localparam int CTRL_W               = 6;

  localparam logic [CTRL_W-1:0]  CTRL_RESET  = 6'h00;
  localparam logic [NUM_CNT-1:0] FLAGS_RESET = 24'h000000;
  localparam logic [NUM_CNT-1:0] MASK_RESET  = 24'h000000;

  // ==========================================================================
  // thresholds and preset values
  localparam logic [CNT_W-1:0] HALF_SCALE      = 32'h8000_0000;
  localparam logic [CNT_W-1:0] FULL_SCALE      = 32'hffff_ffff;
  localparam logic [15:0]      HALF_SCALE_16   = 16'h8000;
  localparam logic [15:0]      FULL_SCALE_16   = 16'hffff;
  localparam logic [CNT_W-1:0] PRESET_HALF_OCT = 32'h7fff_f800;
  localparam logic [CNT_W-1:0] PRESET_HALF_FRM = 32'h7fff_fff0;
  localparam logic [CNT_W-1:0] PRESET_FULL_OCT = 32'hffff_f800;
  localparam logic [CNT_W-1:0] PRESET_FULL_FRM = 32'hffff_fff0;

  // ==========================================================================
  // flag bit of each receive counter
  localparam int RX_ALL_FRAMES_BIT     = 0;
  localparam int RX_ALL_OCTETS_BIT     = 1;
  localparam int RX_GOOD_OCTETS_BIT    = 2;
  localparam int RX_BCAST_BIT          = 3;
  localparam int RX_MCAST_BIT          = 4;
  localparam int RX_CRC_ERR_BIT        = 5;
  localparam int RX_ALIGN_ERR_BIT      = 6;
  localparam int RX_RUNT_ERR_BIT       = 7;
  localparam int RX_JABBER_ERR_BIT     = 8;
  localparam int RX_UNDERSIZE_BIT      = 9;
  localparam int RX_OVERSIZE_BIT       = 10;
  localparam int RX_BUCKET_LE64_BIT    = 11;
  localparam int RX_BUCKET_65_127_BIT  = 12;
  localparam int RX_BUCKET_128_255_BIT = 13;
  localparam int RX_BUCKET_256_511_BIT = 14;
  localparam int RX_BUCKET_512_1023_BIT = 15;
  localparam int RX_BUCKET_1024_MAX_BIT = 16;
  localparam int RX_UCAST_BIT          = 17;
  localparam int RX_LENGTH_ERR_BIT     = 18;
  localparam int RX_RANGE_TYPE_BIT     = 19;
  localparam int RX_PAUSE_BIT          = 20;
  localparam int RX_FIFO_OVERRUN_BIT   = 21;
  localparam int RX_TAGGED_BIT         = 22;
  localparam int RX_WATCHDOG_BIT       = 23;

  // ==========================================================================
  // state types
  typedef struct packed {
    logic [CNT_W-1:0] count;
  } cnt_state_t;

  typedef struct packed {
    logic [CTRL_W-1:0]  ctrl;
    logic [NUM_CNT-1:0] flags;
    logic [NUM_CNT-1:0] mask;
    logic [31:0]        rdData;
    logic               slvErr;
  } top_state_t;

endpackage

/* src/rx_stat_counter.sv */
// one receive statistics counter with threshold event detection
module rx_stat_counter
  import rx_flags_pkg::*;
#(
  parameter bit IS_OCTET = 1'b0
)
(
  input  wire logic             sys_clk,
  input  wire logic             srst,
  cnt_ctrl_if.cnt               ctl,
  input  wire logic             countInc,
  input  wire logic [15:0]      addAmt,
  input  wire logic             readClear,
  output logic      [CNT_W-1:0] count,
  output logic                  thresholdHit
);

  cnt_state_t       st_r;
  cnt_state_t       st_nxt;
  logic [CNT_W:0]   sum;
  logic [CNT_W-1:0] newVal;
  logic             halfHit;
  logic             fullHit;

  always_comb
  begin
    st_nxt  = st_r;
    sum     = {1'b0, st_r.count} + {{(CNT_W + 1 - 16){1'b0}}, addAmt};
    newVal  = sum[CNT_W-1:0];
    halfHit = 1'b0;
    fullHit = 1'b0;
    if (ctl.resetAll)
      st_nxt.count = '0;
    else if (ctl.preset)
      st_nxt.count = ctl.presetFull ? (IS_OCTET ? PRESET_FULL_OCT : PRESET_FULL_FRM)
                                    : (IS_OCTET ? PRESET_HALF_OCT : PRESET_HALF_FRM);
    else if (readClear && ctl.clrOnRead)
      st_nxt.count = '0;
    else if (countInc && !ctl.freeze)
    begin
      // only the step that lands on a threshold counts, no repeat while parked
      halfHit = (st_r.count < HALF_SCALE) && (newVal >= HALF_SCALE || sum[CNT_W]);
      fullHit = (st_r.count != FULL_SCALE) && (sum[CNT_W] || newVal == FULL_SCALE);
      if (sum[CNT_W] && ctl.stopRoll)
        st_nxt.count = FULL_SCALE;
      else
        st_nxt.count = newVal;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign count        = st_r.count;
  assign thresholdHit = halfHit | fullHit;
endmodule

/* src/rx_stat_counter_event_flags.sv */
// receive statistics counters with sticky half/full event flags behind apb
module rx_stat_counter_event_flags
  import rx_flags_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               srst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [NUM_CNT-1:0] rxCountInc,
  input  wire logic [15:0]        rxAllOctetsAdd,
  input  wire logic [15:0]        rxGoodOctetsAdd,
  output logic                    irq
);

  // ==========================================================================
  // declarations
  top_state_t         st_r;
  top_state_t         st_nxt;
  logic               setupPhase;
  logic               wrDone;
  logic               rdDone;
  logic               selCtrl;
  logic               selFlags;
  logic               selMask;
  logic               selCnt;
  logic [4:0]         cntIdx;
  logic               mapped;
  logic [NUM_CNT-1:0] cntHit;
  logic [NUM_CNT-1:0] rdClear;
  logic [CNT_W-1:0]   cntVal [NUM_CNT];
  logic [31:0]        rdMux;

  cnt_ctrl_if ctlBus ();

  // ==========================================================================
  // bus decode
  apb_reg_decode u_decode (
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .setupPhase (setupPhase),
    .wrDone     (wrDone),
    .rdDone     (rdDone),
    .selCtrl    (selCtrl),
    .selFlags   (selFlags),
    .selMask    (selMask),
    .selCnt     (selCnt),
    .cntIdx     (cntIdx),
    .mapped     (mapped)
  );

  // ==========================================================================
  // counters
  assign ctlBus.resetAll   = st_r.ctrl[CTRL_CNT_RESET_BIT];
  assign ctlBus.preset     = st_r.ctrl[CTRL_PRESET_BIT];
  assign ctlBus.presetFull = st_r.ctrl[CTRL_PRESET_FULL_BIT];
  assign ctlBus.freeze     = st_r.ctrl[CTRL_FREEZE_BIT];
  assign ctlBus.stopRoll   = st_r.ctrl[CTRL_STOP_ROLL_BIT];
  assign ctlBus.clrOnRead  = st_r.ctrl[CTRL_CLR_ON_READ_BIT];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CNT; gi++)
    begin : g_cnt
      localparam bit OCT = (gi == RX_ALL_OCTETS_BIT) || (gi == RX_GOOD_OCTETS_BIT);
      logic [15:0] amt;

      // frame counters step by one, octet counters by the frame's byte count
      if (gi == RX_ALL_OCTETS_BIT)
      begin : g_all
        assign amt = rxAllOctetsAdd;
      end
      else if (gi == RX_GOOD_OCTETS_BIT)
      begin : g_good
        assign amt = rxGoodOctetsAdd;
      end
      else
      begin : g_frm
        assign amt = 16'h0001;
      end

      // an apb read always returns the whole word, so lane 7:0 is always covered
      assign rdClear[gi] = rdDone && selCnt && cntIdx == 5'(gi);

      rx_stat_counter #(
        .IS_OCTET (OCT)
      ) u_cnt (
        .sys_clk      (sys_clk),
        .srst         (srst),
        .ctl          (ctlBus.cnt),
        .countInc     (rxCountInc[gi]),
        .addAmt       (amt),
        .readClear    (rdClear[gi]),
        .count        (cntVal[gi]),
        .thresholdHit (cntHit[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // read data select
  always_comb
  begin
    rdMux = 32'h0000_0000;
    if (selCtrl)
      rdMux = {{(32 - CTRL_W){1'b0}}, st_r.ctrl};
    else if (selFlags)
      rdMux = {{(32 - NUM_CNT){1'b0}}, st_r.flags};
    else if (selMask)
      rdMux = {{(32 - NUM_CNT){1'b0}}, st_r.mask};
    else if (selCnt)
      rdMux = cntVal[cntIdx];
  end

  // ==========================================================================
  // register and flag update
  always_comb
  begin
    st_nxt = st_r;

    // self-clearing reset and preset strobes last exactly one cycle
    st_nxt.ctrl[CTRL_CNT_RESET_BIT] = 1'b0;
    st_nxt.ctrl[CTRL_PRESET_BIT]    = 1'b0;
    if (wrDone && selCtrl)
      st_nxt.ctrl = pwdata[CTRL_W-1:0];
    if (wrDone && selMask)
      st_nxt.mask = pwdata[NUM_CNT-1:0];

    // clear first, then set, so a coinciding event survives
    st_nxt.flags = (st_r.flags & ~rdClear) | cntHit;

    // read data and error captured in setup, stable through the access phase
    if (setupPhase)
    begin
      st_nxt.rdData = pwrite ? 32'h0000_0000 : rdMux;
      st_nxt.slvErr = !mapped;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      st_r.ctrl   <= CTRL_RESET;
      st_r.flags  <= FLAGS_RESET;
      st_r.mask   <= MASK_RESET;
      st_r.rdData <= 32'h0000_0000;
      st_r.slvErr <= 1'b0;
    end
    else
      st_r <= st_nxt;
  end

  // ==========================================================================
  // outputs
  assign prdata  = st_r.rdData;
  assign pslverr = st_r.slvErr;
  assign pready  = 1'b1;
  assign irq     = |(st_r.flags & ~st_r.mask);
endmodule

/* verification/rx_flags_monitor.sv */
// port checker for the receive counter event flag block
module rx_flags_monitor
  import rx_flags_pkg::*;
(
  input wire logic               sys_clk,
  input wire logic               srst,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [11:0]        paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic [NUM_CNT-1:0] rxCountInc,
  input wire logic               irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic acc;
  logic cntAcc;
  logic mapOk;
  logic evt;
  assign acc    = psel && penable;
  // counter words are aligned; a stray low address bit is unmapped
  assign cntAcc = paddr >= CNT_BASE_OFFSET && paddr <= 12'h1dc && paddr[1:0] == 2'h0;
  assign mapOk  = cntAcc || paddr == CTRL_OFFSET || paddr == FLAGS_OFFSET || paddr == MASK_OFFSET;
  assign evt    = |rxCountInc || (acc && pwrite);
  // ==========================================================================
  // apb answers
  ready_access_a: assert property (acc |-> pready) else $error("no ready in access");
  unmapped_err_a: assert property (acc && !mapOk |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (acc && mapOk |-> !pslverr) else $error("mapped access refused");
  data_stand_a: assert property (acc |=> $stable(prdata)) else $error("read data moved");
  // ==========================================================================
  // flags and interrupt
  reset_quiet_a: assert property ($fell(srst) |-> !irq && prdata == 32'h0 && !pslverr)
    else $error("outputs not cleared by reset");
  flag_resv_a: assert property (acc && !pwrite && paddr == FLAGS_OFFSET
    |-> prdata[31:24] == 8'h0) else $error("reserved flag bits set");
  irq_hold_a: assert property (irq && !(acc && (pwrite || cntAcc)) |=> irq)
    else $error("interrupt dropped without counter read");
  irq_cause_a: assert property ($rose(irq) |-> $past(evt))
    else $error("interrupt raised without event");
  mask_all_a: assert property (acc && pwrite && paddr == MASK_OFFSET && &pwdata[23:0] |=> !irq)
    else $error("masked interrupt still high");
endmodule

bind rx_stat_counter_event_flags rx_flags_monitor rx_flags_monitor_i (.sys_clk, .srst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rxCountInc, .irq);

/* verification/tb.sv */
// self-checking bench for the receive counter event flag block
module tb
  import rx_flags_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic pready, pslverr, irq, er, sr = 0, cor = 0, fz = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, r1, r2;
  logic [23:0] rxCountInc = '0, ef = '0, mk = '0;
  logic [15:0] rxAllOctetsAdd = '0, rxGoodOctetsAdd = '0;
  logic [31:0] ec [NUM_CNT] = '{default: '0};
  int err_total = 0, samples_checked = 0, seed = 28;

  always #12.5 sys_clk = ~sys_clk;

  rx_stat_counter_event_flags rx_stat_counter_event_flags_i (.sys_clk, .srst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rxCountInc, .rxAllOctetsAdd,
    .rxGoodOctetsAdd, .irq);

  // ==========================================================================
  // checking and closing
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ==========================================================================
  // expected counter and flag model
  function void step(input logic [23:0] m, input logic [15:0] a, g);
    logic [32:0] s;
    for (int i = 0; i < NUM_CNT; i++)
      if (m[i] && !fz && !(sr && ec[i] == FULL_SCALE))
      begin
        s = {1'b0, ec[i]} + (i == 1 ? a : i == 2 ? g : 16'h1);
        // landing on a threshold only; leaving all ones by a wrap raises nothing
        if (ec[i] != FULL_SCALE && ((!ec[i][31] && s[31]) || s[32] || s[31:0] == FULL_SCALE))
          ef[i] = 1'b1;
        ec[i] = (s[32] && sr) ? FULL_SCALE : s[31:0];
      end
  endfunction

  function void preset(input logic full);
    for (int i = 0; i < NUM_CNT; i++)
      ec[i] = (i == 1 || i == 2) ? (full ? PRESET_FULL_OCT : PRESET_HALF_OCT)
                                 : (full ? PRESET_FULL_FRM : PRESET_HALF_FRM);
  endfunction

  // ==========================================================================
  // stimulus tasks, each entered just after a rising edge
  task pulse(input logic [23:0] m, input logic [15:0] a, g);
    rxCountInc <= m;
    rxAllOctetsAdd <= a;
    rxGoodOctetsAdd <= g;
    step(m, a, g);
    @(posedge sys_clk);
  endtask

  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d, input logic [23:0] m);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    rxCountInc <= m;
    // no wait count assumed: only the watchdog ends a hung access
    do @(posedge sys_clk); while (pready !== 1'b1);
    chk(pready, 32'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    rxCountInc <= '0;
    @(posedge sys_clk);
  endtask

  task rdc(input int i, input logic [23:0] m);
    apb(1'b0, CNT_BASE_OFFSET + 12'(4 * i), '0, m);
    chk(rd, ec[i]);
    ef[i] = 1'b0;
    if (cor) ec[i] = '0;
    // with clear on read the read counter loses an increment on its clearing edge
    step(cor ? m & ~(24'h1 << i) : m, '0, '0);
  endtask

  task rdf;
    apb(1'b0, FLAGS_OFFSET, '0, '0);
    chk(rd, {8'h0, ef});
    chk(irq, |(ef & ~mk));
  endtask

  // ==========================================================================
  // scenarios
  initial
  begin
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    rdf;
    apb(1'b0, CTRL_OFFSET, '0, '0);
    chk(rd, 32'h0);
    wr_flags: apb(1'b1, FLAGS_OFFSET, 32'hffff_ffff, '0);
    rdf;
    apb(1'b0, 12'h200, '0, '0);
    chk({er, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, CTRL_OFFSET, 32'h10, '0);
    preset(1'b0);
    rdc(0, '0);
    rdc(1, '0);
    repeat (40)
    begin
      r1 = $random(seed);
      r2 = $random(seed);
      pulse(r1[23:0], r2[15:0] & 16'h00ff, r2[31:16] & 16'h00ff);
    end
    pulse('0, '0, '0);
    rdf;
    rdf;
    rdc(5, '0);
    rdf;
    for (int i = 0; i < NUM_CNT; i++) rdc(i, '0);
    rdf;
    // saturating full scale, then masking
    apb(1'b1, CTRL_OFFSET, 32'h32, '0);
    sr = 1'b1;
    preset(1'b1);
    apb(1'b0, CTRL_OFFSET, '0, '0);
    chk(rd, 32'h22);
    repeat (20) pulse('1, 16'h0100, 16'h0100);
    pulse('0, '0, '0);
    rdf;
    apb(1'b1, MASK_OFFSET, 32'h00ff_ffff, '0);
    mk = '1;
    rdf;
    apb(1'b1, MASK_OFFSET, '0, '0);
    mk = '0;
    apb(1'b1, CTRL_OFFSET, 32'h26, '0);
    cor = 1'b1;
    rdc(0, '0);
    rdc(0, '0);
    // set on the clearing read, then wrap
    apb(1'b1, CTRL_OFFSET, 32'h30, '0);
    sr = 1'b0;
    cor = 1'b0;
    preset(1'b1);
    repeat (14) pulse(24'h1, '0, '0);
    pulse('0, '0, '0);
    rdc(0, 24'h1);
    rdf;
    rdc(0, '0);
    // a wrap out of all ones is no landing on a threshold
    repeat (2) pulse(24'h1, '0, '0);
    pulse('0, '0, '0);
    rdc(0, '0);
    rdf;
    // frozen counters ignore events, then the reset strobe zeroes them and keeps flags
    apb(1'b1, CTRL_OFFSET, 32'h08, '0);
    fz = 1'b1;
    repeat (3) pulse('1, 16'h0010, 16'h0010);
    pulse('0, '0, '0);
    rdc(3, '0);
    apb(1'b1, CTRL_OFFSET, 32'h01, '0);
    fz = 1'b0;
    ec = '{default: '0};
    rdc(4, '0);
    rdf;
    apb(1'b0, CTRL_OFFSET, '0, '0);
    chk(rd, 32'h0);
    report_and_stop;
  end

  initial
  begin
    #(4000 * 25);
    err_total++;
    report_and_stop;
  end
endmodule
